// >>> common/bmb_pkg.sv
// shared constants and types of the breaker command mailbox
package bmb_pkg;

   // ----------------------------------------
   // register map and frame layout
   // ----------------------------------------
   localparam int unsigned FRAME_WORDS = 20;
   localparam logic [15:0] FRAME_BASE = 16'h1f40;
   localparam logic [15:0] CODE_ADDR = 16'h1f54;
   localparam logic [15:0] STAT_ADDR = 16'h1f55;
   localparam logic [4:0] W_CODE = 5'h00;
   localparam logic [4:0] W_LEN = 5'h01;
   localparam logic [4:0] W_DEST = 5'h02;
   localparam logic [4:0] W_FIXED = 5'h03;
   localparam logic [4:0] W_PW_HI = 5'h04;
   localparam logic [4:0] W_PW_LO = 5'h05;
   localparam logic [4:0] W_PAR_FIRST = 5'h06;
   localparam logic [4:0] W_PAR_LAST = 5'h10;
   localparam logic [4:0] W_SETUP = 5'h11;
   localparam logic [19:0] MASK_ALL = 20'hfffff;
   localparam logic [19:0] MASK_NONE = 20'h00000;

   // ----------------------------------------
   // frame values and reset values
   // ----------------------------------------
   localparam logic [15:0] CMD_OPEN = 16'h0388;
   localparam logic [15:0] LEN_FIXED = 16'h000a;
   localparam logic [15:0] DEST_OPEN = 16'h1501;
   localparam logic [15:0] FIXED_ONE = 16'h0001;
   localparam logic [15:0] SETUP_0 = 16'h1f53;
   localparam logic [15:0] SETUP_1 = 16'h1f54;
   localparam logic [15:0] SETUP_2 = 16'h1f55;
   localparam logic [15:0] STAT_BUSY = 16'h0003;
   localparam logic [7:0] STAT_HI = 8'h00;
   localparam logic [15:0] CODE_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0000;
   localparam logic [15:0] DATA_RST = 16'h0000;

   // ----------------------------------------
   // result codes
   // ----------------------------------------
   localparam logic [7:0] RC_OK = 8'h00;
   localparam logic [7:0] RC_RIGHTS = 8'h01;
   localparam logic [7:0] RC_NO_CMD = 8'h13;
   localparam logic [7:0] RC_BAD_ARG = 8'h14;
   localparam logic [7:0] RC_TIMEOUT = 8'h16;
   localparam logic [7:0] RC_BAD_DEST = 8'h18;
   localparam logic [7:0] RC_IS_OPEN = 8'h99;
   localparam logic [7:0] RC_PREV_BUSY = 8'h9e;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam longint unsigned CLK_HZ = 50_000_000;
   localparam longint unsigned OPEN_TIMEOUT_MS = 100;
   localparam int unsigned OPEN_TIMEOUT_CYC = int'(CLK_HZ / 1000 * OPEN_TIMEOUT_MS);
   localparam logic [31:0] CNT_RST = 32'h0000_0000;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef logic [19:0][15:0] bmb_frame_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bmb_req_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CHECK = 3'b010,
      ST_WAIT = 3'b100
   } bmb_state_e;

endpackage

// >>> rtl/bmb_frame_check.sv
// validation of a captured command frame into a result code
`timescale 1ns/100ps
`default_nettype none

module bmb_frame_check
(
   input wire bmb_pkg::bmb_frame_t frame,
   input wire logic [31:0] pw_admin,
   input wire logic [31:0] pw_oper,
   input wire logic brk_is_open,
   output logic [7:0] result
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic params_zero(input bmb_pkg::bmb_frame_t f);
      logic z;
      z = 1'b1;
      for (int i = int'(bmb_pkg::W_PAR_FIRST); i <= int'(bmb_pkg::W_PAR_LAST); i++)
      begin
         if (f[i] != 16'h0000)
         begin
            z = 1'b0;
         end
      end
      return z;
   endfunction

   // ----------------------------------------
   // field checks
   // ----------------------------------------
   wire logic [31:0] pw_given;
   wire logic is_open_cmd;
   wire logic len_ok;
   wire logic dest_ok;
   wire logic shape_ok;
   wire logic rights_ok;

   assign is_open_cmd = frame[bmb_pkg::W_CODE] == bmb_pkg::CMD_OPEN;
   // first character in the upper byte of the upper word
   assign pw_given = {frame[bmb_pkg::W_PW_HI], frame[bmb_pkg::W_PW_LO]};
   assign rights_ok = (pw_given == pw_admin) || (pw_given == pw_oper);
   assign len_ok = frame[bmb_pkg::W_LEN] == bmb_pkg::LEN_FIXED;
   assign dest_ok = frame[bmb_pkg::W_DEST] == bmb_pkg::DEST_OPEN;
   // malformed fixed words are refused rather than trusted
   assign shape_ok = (frame[bmb_pkg::W_FIXED] == bmb_pkg::FIXED_ONE)
      && params_zero(frame)
      && (frame[bmb_pkg::W_SETUP] == bmb_pkg::SETUP_0)
      && (frame[bmb_pkg::W_SETUP + 5'h01] == bmb_pkg::SETUP_1)
      && (frame[bmb_pkg::W_SETUP + 5'h02] == bmb_pkg::SETUP_2);

   // unknown command first, breaker state last
   assign result = !is_open_cmd ? bmb_pkg::RC_NO_CMD :
      !(len_ok && shape_ok) ? bmb_pkg::RC_BAD_ARG :
      !dest_ok ? bmb_pkg::RC_BAD_DEST :
      !rights_ok ? bmb_pkg::RC_RIGHTS :
      brk_is_open ? bmb_pkg::RC_IS_OPEN :
      bmb_pkg::RC_OK;

endmodule
`default_nettype wire

// >>> rtl/bmb_mailbox.sv
// command mailbox: frame capture, execution sequencing, status readback
//
// Operation
// - word zero is the command code; 904 opens the breaker
// - word one is parameter length; ten when no parameters
// - words four and five hold a four-character password, first char high
// - status reads 0x0003 while executing; master polls until it changes
// - after execution the processed command code reads back at 8020
// - status low byte holds the result; nonzero means failure
// - low byte zero when the command succeeded
// - result 1 for insufficient password rights
// - result 19 for an unimplemented command code
// - result 158 for a command arriving while another is running
// - result 153 when opening an already open breaker
`timescale 1ns/100ps
`default_nettype none

module bmb_mailbox
#(
   parameter int unsigned OPEN_TIMEOUT_CYC = bmb_pkg::OPEN_TIMEOUT_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire bmb_pkg::bmb_req_s req,
   input wire logic [31:0] pw_admin,
   input wire logic [31:0] pw_oper,
   input wire logic brk_is_open,
   input wire logic brk_open_done,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic brk_open_req
);

   // ----------------------------------------
   // frame area decode
   // ----------------------------------------
   logic [15:0] frame_q [bmb_pkg::FRAME_WORDS];
   logic [19:0] mask_q;
   logic [19:0] mask_d;
   wire logic [15:0] addr_off;
   wire logic [4:0] idx;
   wire logic in_frame;
   wire logic frame_done;
   wire bmb_pkg::bmb_frame_t frame_packed;

   assign addr_off = req.addr - bmb_pkg::FRAME_BASE;
   assign idx = addr_off[4:0];
   assign in_frame = req.wr && (req.addr >= bmb_pkg::FRAME_BASE)
      && (addr_off < 16'(bmb_pkg::FRAME_WORDS));
   // a write to word zero opens a fresh frame, dropping stale partial ones
   assign mask_d = !in_frame ? mask_q :
      (idx == bmb_pkg::W_CODE) ? 20'h00001 : (mask_q | (20'h00001 << idx));
   assign frame_done = in_frame && (mask_d == bmb_pkg::MASK_ALL);

   for (genvar g = 0; g < bmb_pkg::FRAME_WORDS; g++)
   begin : g_pack
      assign frame_packed[g] = frame_q[g];
   end

   always_ff @(posedge core_clk)
   begin
      if (ce && in_frame)
      begin
         frame_q[idx] <= req.wdata;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         mask_q <= bmb_pkg::MASK_NONE;
      end
      else if (ce)
      begin
         mask_q <= frame_done ? bmb_pkg::MASK_NONE : mask_d;
      end
   end

   // ----------------------------------------
   // frame validation
   // ----------------------------------------
   wire logic [7:0] check_rc;

   bmb_frame_check i_bmb_frame_check
   (
      .frame(frame_packed),
      .pw_admin(pw_admin),
      .pw_oper(pw_oper),
      .brk_is_open(brk_is_open),
      .result(check_rc)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   bmb_pkg::bmb_state_e state_q;
   bmb_pkg::bmb_state_e state_d;
   logic [31:0] cnt_q;
   logic [15:0] cmd_q;
   logic [15:0] code_q;
   logic [15:0] stat_q;
   logic rej_q;
   logic [15:0] rej_code_q;
   wire logic is_idle;
   wire logic is_check;
   wire logic is_wait;
   wire logic timed_out;
   wire logic check_fail;
   wire logic wait_end;
   wire logic report_rej;
   wire logic new_rej;
   wire logic [7:0] wait_rc;

   assign is_idle = state_q == bmb_pkg::ST_IDLE;
   assign is_check = state_q == bmb_pkg::ST_CHECK;
   assign is_wait = state_q == bmb_pkg::ST_WAIT;
   assign timed_out = cnt_q >= (OPEN_TIMEOUT_CYC - 1);
   assign check_fail = is_check && (check_rc != bmb_pkg::RC_OK);
   assign wait_end = is_wait && (brk_open_done || timed_out);
   assign wait_rc = brk_open_done ? bmb_pkg::RC_OK : bmb_pkg::RC_TIMEOUT;
   // a frame landing while not idle is refused and reported on return to idle, lost if a new frame completes in that same cycle
   assign new_rej = frame_done && !is_idle;
   assign report_rej = is_idle && rej_q;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         bmb_pkg::ST_IDLE:
         begin
            if (frame_done)
            begin
               state_d = bmb_pkg::ST_CHECK;
            end
         end
         bmb_pkg::ST_CHECK:
         begin
            state_d = check_fail ? bmb_pkg::ST_IDLE : bmb_pkg::ST_WAIT;
         end
         bmb_pkg::ST_WAIT:
         begin
            if (wait_end)
            begin
               state_d = bmb_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_d = bmb_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_q <= bmb_pkg::ST_IDLE;
      end
      else if (ce)
      begin
         state_q <= state_d;
      end
   end

   // breaker response watchdog
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cnt_q <= bmb_pkg::CNT_RST;
      end
      else if (ce)
      begin
         cnt_q <= is_wait ? cnt_q + 32'h1 : bmb_pkg::CNT_RST;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cmd_q <= bmb_pkg::CODE_RST;
         brk_open_req <= 1'b0;
      end
      else if (ce)
      begin
         if (is_check)
         begin
            cmd_q <= frame_q[bmb_pkg::W_CODE];
         end
         brk_open_req <= is_check && !check_fail;
      end
   end

   // refusal flag: a new refusal wins over the clear of the old one
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rej_q <= 1'b0;
         rej_code_q <= bmb_pkg::CODE_RST;
      end
      else if (ce)
      begin
         if (new_rej)
         begin
            rej_q <= 1'b1;
            rej_code_q <= frame_q[bmb_pkg::W_CODE];
         end
         else if (report_rej)
         begin
            rej_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // result and status registers
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         code_q <= bmb_pkg::CODE_RST;
         stat_q <= bmb_pkg::STAT_RST;
      end
      else if (ce)
      begin
         if (is_idle && frame_done)
         begin
            stat_q <= bmb_pkg::STAT_BUSY;
         end
         else if (report_rej)
         begin
            code_q <= rej_code_q;
            stat_q <= {bmb_pkg::STAT_HI, bmb_pkg::RC_PREV_BUSY};
         end
         else if (check_fail)
         begin
            code_q <= frame_q[bmb_pkg::W_CODE];
            stat_q <= {bmb_pkg::STAT_HI, check_rc};
         end
         else if (wait_end)
         begin
            code_q <= cmd_q;
            stat_q <= {bmb_pkg::STAT_HI, wait_rc};
         end
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   wire logic [15:0] rd_mux;

   // frame area is write-only and reads as zero, like any unmapped word
   assign rd_mux = (req.addr == bmb_pkg::CODE_ADDR) ? code_q :
      (req.addr == bmb_pkg::STAT_ADDR) ? stat_q : bmb_pkg::DATA_RST;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rd_data <= bmb_pkg::DATA_RST;
         rd_valid <= 1'b0;
      end
      else if (ce)
      begin
         rd_data <= req.rd ? rd_mux : rd_data;
         rd_valid <= req.rd;
      end
   end

endmodule
`default_nettype wire

// >>> testbench/bmb_breaker_model.sv
// behavioural breaker mechanism answering open requests
`timescale 1ns/100ps
`default_nettype none

module bmb_breaker_model
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic brk_open_req,
   input wire logic [7:0] delay,
   input wire logic mute,
   input wire logic reclose,
   output logic brk_is_open,
   output logic brk_open_done
);
   logic [7:0] cnt_q;
   logic busy_q;

   // mute leaves the request unanswered so the wait runs out
   always_ff @(posedge core_clk)
   begin
      brk_open_done <= 1'b0;
      if (!rst_n || reclose)
      begin
         busy_q <= 1'b0;
         brk_is_open <= 1'b0;
      end
      else if (brk_open_req && !mute)
      begin
         busy_q <= 1'b1;
         cnt_q <= delay;
      end
      else if (busy_q && cnt_q == 8'h00)
      begin
         busy_q <= 1'b0;
         brk_open_done <= 1'b1;
         brk_is_open <= 1'b1;
      end
      else if (busy_q)
         cnt_q <= cnt_q - 8'h01;
   end
endmodule

`default_nettype wire

// >>> testbench/bmb_mailbox_sva.sv
// port assertions of the command mailbox
`timescale 1ns/100ps
`default_nettype none

module bmb_mailbox_sva
#(
   parameter int unsigned OPEN_TIMEOUT_CYC = bmb_pkg::OPEN_TIMEOUT_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire bmb_pkg::bmb_req_s req,
   input wire logic [31:0] pw_admin,
   input wire logic [31:0] pw_oper,
   input wire logic brk_is_open,
   input wire logic brk_open_done,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic brk_open_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   wire logic in_frame = req.addr >= 16'h1f40 && req.addr < 16'h1f54;
   wire logic rd_map = req.addr == 16'h1f54 || req.addr == 16'h1f55;
   logic wr1_q;
   logic wr2_q;

   // frame write two edges back is the only way into an open request
   always_ff @(posedge core_clk)
   begin
      wr1_q <= ce && req.wr && in_frame;
      wr2_q <= wr1_q;
   end

   sequence open_pulse_s;
      brk_open_req ##1 !brk_open_req [*8];
   endsequence

   rd_answer_a: assert property (ce && req.rd |=> rd_valid)
      else $error("read not answered");
   rd_single_a: assert property (ce && !req.rd |=> !rd_valid)
      else $error("read answer without read");
   rd_hold_a: assert property (ce && !req.rd |=> $stable(rd_data))
      else $error("read data moved");
   unmapped_zero_a: assert property (ce && req.rd && !rd_map |=> rd_data == 16'h0000)
      else $error("non readable place gave data");
   status_hi_a: assert property (ce && req.rd && req.addr == 16'h1f55 |=> rd_data[15:8] == 8'h00)
      else $error("status high byte set");
   open_single_a: assert property (brk_open_req |-> open_pulse_s)
      else $error("open request repeated");
   open_closed_a: assert property (brk_open_req |-> !$past(brk_is_open))
      else $error("open request on open breaker");
   open_after_frame_a: assert property (brk_open_req |-> wr2_q)
      else $error("open request without frame end");
endmodule

bind bmb_mailbox bmb_mailbox_sva #(.OPEN_TIMEOUT_CYC(OPEN_TIMEOUT_CYC)) i_bmb_mailbox_sva (
   .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .req(req), .pw_admin(pw_admin),
   .pw_oper(pw_oper), .brk_is_open(brk_is_open), .brk_open_done(brk_open_done),
   .rd_data(rd_data), .rd_valid(rd_valid), .brk_open_req(brk_open_req));

`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the command mailbox
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
      end \
   end

module tb_top;
   typedef struct packed {
      logic [15:0] code;
      logic [15:0] len;
      logic [31:0] pw;
      logic reclose;
      logic mute;
      logic [7:0] dly;
      logic [7:0] rc;
   } bmb_case_s;

   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   bmb_pkg::bmb_req_s req = '0;
   logic [31:0] pw_admin = 32'h4142_6364;
   logic [31:0] pw_oper = 32'h5077_3537;
   logic [7:0] dly = 8'h00;
   logic mute = 1'b0;
   logic reclose = 1'b0;
   wire logic brk_is_open;
   wire logic brk_open_done;
   wire logic rd_valid;
   wire logic brk_open_req;
   wire logic [15:0] rd_data;
   logic [15:0] rv;
   int error_cnt = 0;
   int total_checks = 0;
   bmb_case_s cases [6];

   always #10 core_clk = ~core_clk;

   bmb_mailbox #(.OPEN_TIMEOUT_CYC(20)) i_bmb_mailbox (.core_clk(core_clk), .rst_n(rst_n),
      .ce(ce), .req(req), .pw_admin(pw_admin), .pw_oper(pw_oper), .brk_is_open(brk_is_open),
      .brk_open_done(brk_open_done), .rd_data(rd_data), .rd_valid(rd_valid),
      .brk_open_req(brk_open_req));
   bmb_breaker_model i_bmb_breaker_model (.core_clk(core_clk), .rst_n(rst_n),
      .brk_open_req(brk_open_req), .delay(dly), .mute(mute), .reclose(reclose),
      .brk_is_open(brk_is_open), .brk_open_done(brk_open_done));

   // ----------------------------------------
   // register access
   // ----------------------------------------
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge core_clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge core_clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge core_clk);
      req.rd = 1'b0;
      `CHK("rd_valid", 1'b1, rd_valid)
      d = rd_data;
   endtask

   // first n words of an open-style frame, one word per cycle
   task automatic send(input logic [15:0] code, input logic [15:0] len,
                       input logic [31:0] pw, input int n);
      bmb_pkg::bmb_frame_t f;
      f = '0;
      f[0] = code;
      f[1] = len;
      f[2] = 16'h1501;
      f[3] = 16'h0001;
      f[4] = pw[31:16];
      f[5] = pw[15:0];
      f[17] = 16'h1f53;
      f[18] = 16'h1f54;
      f[19] = 16'h1f55;
      for (int i = 0; i < n; i++)
         wr(16'h1f40 + 16'(i), f[i]);
   endtask

   task automatic finish_cmd(input logic [15:0] code, input logic [7:0] rc);
      rv = 16'h0003;
      for (int i = 0; i < 40 && rv === 16'h0003; i++)
         rd(16'h1f55, rv);
      rd(16'h1f55, rv);
      `CHK("status", {8'h00, rc}, rv)
      rd(16'h1f54, rv);
      `CHK("code", code, rv)
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      cases[0] = '{16'h0388, 16'h000a, 32'h5077_3537, 1'b1, 1'b0, 8'h0c, 8'h00};
      cases[1] = '{16'h0388, 16'h000a, 32'h4142_6364, 1'b0, 1'b0, 8'h00, 8'h99};
      cases[2] = '{16'h0388, 16'h000a, 32'h4142_6365, 1'b1, 1'b0, 8'h00, 8'h01};
      cases[3] = '{16'h0389, 16'h000a, 32'h4142_6364, 1'b0, 1'b0, 8'h00, 8'h13};
      cases[4] = '{16'h0388, 16'h000c, 32'h4142_6364, 1'b0, 1'b0, 8'h00, 8'h14};
      cases[5] = '{16'h0388, 16'h000a, 32'h4142_6364, 1'b0, 1'b1, 8'h00, 8'h16};
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      rd(16'h1f55, rv);
      `CHK("status after reset", 16'h0000, rv)
      rd(16'h1f54, rv);
      `CHK("code after reset", 16'h0000, rv)
      rd(16'h1f40, rv);
      `CHK("write-only frame read", 16'h0000, rv)
      rd(16'h0000, rv);
      `CHK("unmapped read", 16'h0000, rv)
      $display("test reset done");
      send(16'h0388, 16'h000a, pw_admin, 19);
      rd(16'h1f55, rv);
      `CHK("status partial frame", 16'h0000, rv)
      // last word offered with the clock enable low must not complete the frame
      @(negedge core_clk);
      ce = 1'b0;
      wr(16'h1f53, 16'h1f55);
      @(negedge core_clk);
      req.wr = 1'b0;
      ce = 1'b1;
      rd(16'h1f55, rv);
      `CHK("status frozen write", 16'h0000, rv)
      wr(16'h1f53, 16'h1f55);
      rd(16'h1f55, rv);
      `CHK("status busy", 16'h0003, rv)
      finish_cmd(16'h0388, 8'h00);
      $display("test partial frame done");
      for (int i = 0; i < 6; i++)
      begin
         @(negedge core_clk);
         reclose = cases[i].reclose;
         mute = cases[i].mute;
         dly = cases[i].dly;
         @(negedge core_clk);
         reclose = 1'b0;
         send(cases[i].code, cases[i].len, cases[i].pw, 20);
         finish_cmd(cases[i].code, cases[i].rc);
         $display("test case %0d done", i);
      end
      // second frame lands while the first still waits on the breaker
      send(16'h0388, 16'h000a, pw_admin, 20);
      send(16'h0389, 16'h000a, pw_admin, 20);
      finish_cmd(16'h0389, 8'h9e);
      $display("test busy refusal done");
      // destination word overwritten before the frame completes
      send(16'h0388, 16'h000a, pw_admin, 19);
      wr(16'h1f42, 16'h1502);
      wr(16'h1f53, 16'h1f55);
      finish_cmd(16'h0388, 8'h18);
      $display("test bad destination done");
      complete_run();
   end

   initial
   begin
      #200000;
      error_cnt++;
      complete_run();
   end
endmodule

`default_nettype wire
